// ### logic/clk_gen_pkg.sv
// Purpose: Shared constants for the clock generation and distribution block.
// Assumes: One 100 MHz system clock; slower clocks are one-cycle enables.
// Notes: Oscillator rates are phase-accumulator increments on the system clock.
package clk_gen_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_MHZ = 100;
  localparam int PLL_LOCK_TIME_US = 250;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * MCLK_MHZ;
  localparam int USB_FRAME_US = 1000;
  // ----------------------------------------
  // Clock source indices into the 8-input multiplexers
  // ----------------------------------------
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_FAST_XTAL = 3'h1;
  localparam logic [2:0] SRC_DOUBLER = 3'h2;
  localparam logic [2:0] SRC_INTERCONNECT = 3'h3;
  localparam logic [2:0] SRC_PLL = 3'h4;
  localparam logic [2:0] SRC_LOW_SPEED = 3'h5;
  localparam logic [2:0] SRC_WATCH = 3'h6;
  localparam logic [2:0] SRC_MASTER = 3'h7;
  localparam int NUM_SOURCES = 7;
  // ----------------------------------------
  // Reference selects for the doubler and the PLL
  // ----------------------------------------
  localparam logic [1:0] REF_MAIN = 2'h0;
  localparam logic [1:0] REF_FAST_XTAL = 2'h1;
  localparam logic [1:0] REF_INTERCONNECT = 2'h2;
  // ----------------------------------------
  // Counts and widths
  // ----------------------------------------
  localparam int NUM_DIG_DIV = 8;
  localparam int NUM_ANA_DIV = 4;
  localparam int DIV_W = 16;
  localparam int CPU_DIV_W = 4;
  localparam int CTW_W = 13;
  localparam int FTW_W = 5;
  localparam int PLL_P_W = 6;
  localparam int PLL_Q_W = 6;
  localparam int PLL_Q_MIN = 4;
  localparam int ACC_W = 16;
  localparam logic [1:0] THIRD_DIV_LAST = 2'h2;
  localparam logic [6:0] SLOW_DIV_LAST = 7'h63;
  localparam logic [14:0] WATCH_SECOND_LAST = 15'h7FFF;
  localparam logic [7:0] TRIM_MAX = 8'h7F;
  localparam logic [7:0] TRIM_MIN = 8'h80;
  // ----------------------------------------
  // Main oscillator ranges: 3, 6, 12, 24, 48, 62 MHz
  // ----------------------------------------
  localparam int NUM_RANGES = 6;
  localparam logic [2:0] RANGE_48 = 3'h4;
  localparam logic [15:0] INC_3 = 16'h07AE;
  localparam logic [15:0] INC_6 = 16'h0F5C;
  localparam logic [15:0] INC_12 = 16'h1EB8;
  localparam logic [15:0] INC_24 = 16'h3D71;
  localparam logic [15:0] INC_48 = 16'h7AE1;
  localparam logic [15:0] INC_62 = 16'h9EB8;
  localparam logic [15:0] KHZ_3 = 16'h0BB8;
  localparam logic [15:0] KHZ_6 = 16'h1770;
  localparam logic [15:0] KHZ_12 = 16'h2EE0;
  localparam logic [15:0] KHZ_24 = 16'h5DC0;
  localparam logic [15:0] KHZ_48 = 16'hBB80;
  localparam logic [15:0] KHZ_62 = 16'hF230;
endpackage

// ### logic/clk_divider.sv
// Purpose: One programmable clock divider with its own 8-input source select.
// Assumes: Source clocks arrive as one-cycle enables on mclk.
// Notes: New select and divide values are taken only at a period boundary.
`timescale 1ns/100ps
module clk_divider import clk_gen_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Sources and settings
  input wire logic [7:0] src_tick,
  input wire logic [2:0] sel,
  input wire logic [W-1:0] div,
  // Divided clock
  output logic clk_out,
  output logic tick_out
);
  logic [2:0] cur_sel;
  logic [W-1:0] cur_div;
  logic [W-1:0] cnt;
  logic [W-1:0] half;
  logic [W-1:0] last;
  logic in_tick;

  assign in_tick = src_tick[cur_sel];
  // Values below two divide by two.
  assign last = (cur_div < W'(2)) ? W'(1) : cur_div - W'(1);
  assign half = (last + W'(1)) >> 1;

  // ----------------------------------------
  // Period counter and shadowed settings
  // ----------------------------------------
  // Settings load only at the wrap so no runt period can appear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      cur_sel <= SRC_MASTER;
      cur_div <= W'(2);
    end else if (in_tick) begin
      if (cnt == last) begin
        cnt <= '0;
        cur_sel <= sel;
        cur_div <= div;
      end else begin
        cnt <= cnt + W'(1);
      end
    end
  end

  // ----------------------------------------
  // Registered output, resynchronised to mclk
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= in_tick && (cnt == last);
      if (in_tick && cnt == last) begin
        clk_out <= 1'b1;
      end else if (in_tick && cnt == half - W'(1)) begin
        clk_out <= 1'b0;
      end
    end
  end

  AST_DIV_DEGLITCH: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(clk_out) |-> $past(in_tick)) else $error("Divider output moved without source tick.");
  AST_DIV_RISE: assert property (@(posedge mclk) disable iff (!rst_n)
    tick_out |-> $rose(clk_out)) else $error("Divider tick without rising output.");
endmodule

// ### logic/clock_generation_distribution.sv
// Purpose: Clock sources, dividers, tick counters and PLL lock for the device.
// Assumes: Oscillator and pin clocks are slow next to mclk and are synchronised.
// Notes: Every divided clock is a level plus a one-cycle enable on mclk; source clocks are one-cycle enables only.
// What this block does
// - Seven clock sources feed the distribution.
// - Eight 16-bit digital clock dividers.
// - Four 16-bit analog clock dividers.
// - One 16-bit bus clock divider.
// - One 4-bit CPU clock divider.
// - Each digital and analog divider selects its own source.
// - Doubler gives twice its selected input rate.
// - PLL input and feedback dividers multiply reference.
// - PLL reference selectable; lock flag after 250 us.
// - PLL passes reference until lock; lock pulse out.
// - Main oscillator six ranges, each trimmed separately.
// - Main oscillator may lock to USB frames.
// - Low-speed oscillator gives 1, 33, 100 kHz.
// - 33 kHz is 100 kHz divided by three.
// - Central tick counter: free 13-bit at 1 kHz.
// - Central counter stops in hibernate or debug halt.
// - Central counter gives periodic interrupt and wake.
// - Firmware may reset central counter anytime.
// - Fast tick counter 5-bit, wraps at terminal.
// - Fast counter interrupts at terminal when enabled.
// - Watch crystal feeds sleep timer; one-second pulse.
// - Dividers: 8-input mux, 50% duty for even divides, resynchronised.
// - Bus divider from master; CPU from bus.
`timescale 1ns/100ps
module clock_generation_distribution import clk_gen_pkg::*; #(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Oscillator and pin clocks from outside
  input wire logic fast_crystal_osc,
  input wire logic interconnect_clk,
  input wire logic low_speed_osc,
  input wire logic watch_crystal_osc,
  input wire logic usb_frame,
  // Source configuration
  input wire logic [2:0] main_range,
  input wire logic [47:0] main_trim,
  input wire logic usb_lock_en,
  input wire logic [1:0] doubler_ref,
  input wire logic [2:0] master_sel,
  // PLL configuration
  input wire logic pll_en,
  input wire logic [1:0] pll_ref,
  input wire logic [PLL_P_W-1:0] pll_p,
  input wire logic [PLL_Q_W-1:0] pll_q,
  // Divider configuration
  input wire logic [23:0] dig_sel,
  input wire logic [127:0] dig_div,
  input wire logic [11:0] ana_sel,
  input wire logic [63:0] ana_div,
  input wire logic [15:0] bus_div,
  input wire logic [3:0] cpu_div,
  // Tick counter control
  input wire logic hibernate,
  input wire logic debug_halt,
  input wire logic ctw_clear,
  input wire logic [3:0] ctw_tap,
  input wire logic [FTW_W-1:0] ftw_terminal,
  input wire logic ftw_irq_en,
  // Source clocks out
  output logic main_osc_tick,
  output logic doubler_tick,
  output logic pll_tick,
  output logic master_tick,
  output logic hundred_khz_clock,
  output logic third_rate_clock,
  output logic slow_tick_clock,
  output logic watch_tick,
  // Divided clocks out
  output logic [7:0] dig_clk,
  output logic [7:0] dig_tick,
  output logic [3:0] ana_clk,
  output logic [3:0] ana_tick,
  output logic bus_clk,
  output logic bus_tick,
  output logic cpu_clk,
  output logic cpu_tick,
  // Status and events
  output logic pll_locked,
  output logic pll_lock_event,
  output logic [CTW_W-1:0] central_tick_counter,
  output logic ctw_irq,
  output logic ctw_wake,
  output logic [FTW_W-1:0] ftw_count,
  output logic ftw_irq,
  output logic rtc_second
);
  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [4:0] sync1, sync2, sync3;
  logic [4:0] rise, anyedge;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {usb_frame, watch_crystal_osc, low_speed_osc, interconnect_clk, fast_crystal_osc};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign rise = sync2 & ~sync3;
  assign anyedge = sync2 ^ sync3;

  // ----------------------------------------
  // Main oscillator with per-range trim and USB lock
  // ----------------------------------------
  function automatic logic [15:0] range_lut(input logic [2:0] r, input logic khz);
    logic [15:0] v;
    v = 16'h0000;
    case (r)
      3'h0: v = khz ? KHZ_3 : INC_3;
      3'h1: v = khz ? KHZ_6 : INC_6;
      3'h2: v = khz ? KHZ_12 : INC_12;
      3'h3: v = khz ? KHZ_24 : INC_24;
      3'h4: v = khz ? KHZ_48 : INC_48;
      3'h5: v = khz ? KHZ_62 : INC_62;
      default: v = khz ? KHZ_3 : INC_3;
    endcase
    return v;
  endfunction

  logic [ACC_W-1:0] main_acc;
  logic [ACC_W-1:0] main_inc;
  logic [7:0] range_trim;
  logic [7:0] usb_corr;
  logic [15:0] usb_count;
  logic [15:0] usb_target;
  logic main_msb_q;
  logic [2:0] range_idx;

  assign range_idx = (main_range < 3'(NUM_RANGES)) ? main_range : 3'h0;
  assign range_trim = main_trim[8*range_idx +: 8];
  assign main_inc = range_lut(range_idx, 1'b0) + {{8{range_trim[7]}}, range_trim}
                    + {{8{usb_corr[7]}}, usb_corr};
  assign usb_target = range_lut(range_idx, 1'b1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      main_acc <= '0;
      main_msb_q <= 1'b0;
      main_osc_tick <= 1'b0;
    end else begin
      {main_osc_tick, main_acc} <= {1'b0, main_acc} + {1'b0, main_inc};
      main_msb_q <= main_acc[ACC_W-1];
    end
  end

  // The frame count nudges a signed correction, saturating so it cannot wrap.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      usb_count <= '0;
      usb_corr <= '0;
    end else if (!usb_lock_en) begin
      usb_count <= '0;
      usb_corr <= '0;
    end else if (rise[4]) begin
      usb_count <= '0;
      if (usb_count > usb_target && usb_corr != TRIM_MIN) begin
        usb_corr <= usb_corr - 8'h01;
      end else if (usb_count < usb_target && usb_corr != TRIM_MAX) begin
        usb_corr <= usb_corr + 8'h01;
      end
    end else if (main_osc_tick && usb_count != 16'hFFFF) begin
      usb_count <= usb_count + 16'h0001;
    end
  end

  // ----------------------------------------
  // Doubler: both edges of the selected reference
  // ----------------------------------------
  always_comb begin
    case (doubler_ref)
      REF_MAIN: doubler_tick = main_acc[ACC_W-1] ^ main_msb_q;
      REF_FAST_XTAL: doubler_tick = anyedge[0];
      REF_INTERCONNECT: doubler_tick = anyedge[1];
      default: doubler_tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Fractional PLL and lock timer
  // ----------------------------------------
  logic ref_tick;
  logic [PLL_Q_W+PLL_P_W:0] pll_acc;
  logic [PLL_P_W-1:0] p_eff;
  logic [31:0] lock_cnt;
  logic [PLL_P_W+PLL_Q_W+3:0] pll_cfg_q;
  logic pll_out;

  always_comb begin
    case (pll_ref)
      REF_MAIN: ref_tick = main_osc_tick;
      REF_FAST_XTAL: ref_tick = rise[0];
      REF_INTERCONNECT: ref_tick = rise[1];
      default: ref_tick = 1'b0;
    endcase
  end
  assign p_eff = (pll_p == '0) ? PLL_P_W'(1) : pll_p;

  // Each reference tick adds Q, each output pulse removes P: rate = ref * Q / P.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_acc <= '0;
      pll_out <= 1'b0;
    end else if (!pll_en) begin
      pll_acc <= '0;
      pll_out <= 1'b0;
    end else begin
      pll_out <= (pll_acc >= (PLL_Q_W+PLL_P_W+1)'(p_eff));
      if (pll_acc >= (PLL_Q_W+PLL_P_W+1)'(p_eff)) begin
        pll_acc <= pll_acc - (PLL_Q_W+PLL_P_W+1)'(p_eff)
                   + (ref_tick ? (PLL_Q_W+PLL_P_W+1)'(pll_q) : '0);
      end else if (ref_tick) begin
        pll_acc <= pll_acc + (PLL_Q_W+PLL_P_W+1)'(pll_q);
      end
    end
  end

  // Any change of reference or ratio restarts the lock timer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= '0;
      pll_locked <= 1'b0;
      pll_lock_event <= 1'b0;
      pll_cfg_q <= '0;
    end else begin
      pll_cfg_q <= {pll_ref, pll_p, pll_q, pll_en, 1'b0};
      pll_lock_event <= 1'b0;
      if (!pll_en || pll_cfg_q != {pll_ref, pll_p, pll_q, pll_en, 1'b0}) begin
        lock_cnt <= '0;
        pll_locked <= 1'b0;
      end else if (lock_cnt == 32'(LOCK_CYCLES - 1)) begin
        pll_locked <= 1'b1;
        pll_lock_event <= !pll_locked;
      end else begin
        lock_cnt <= lock_cnt + 32'h1;
      end
    end
  end
  assign pll_tick = pll_locked ? pll_out : (pll_en && ref_tick);

  // ----------------------------------------
  // Low-speed clocks and watch crystal
  // ----------------------------------------
  logic [1:0] third_cnt;
  logic [6:0] slow_cnt;
  logic [14:0] watch_cnt;

  assign hundred_khz_clock = rise[2];
  assign watch_tick = rise[3];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      third_cnt <= '0;
      slow_cnt <= '0;
      watch_cnt <= '0;
      third_rate_clock <= 1'b0;
      slow_tick_clock <= 1'b0;
      rtc_second <= 1'b0;
    end else begin
      third_rate_clock <= hundred_khz_clock && third_cnt == THIRD_DIV_LAST;
      slow_tick_clock <= hundred_khz_clock && slow_cnt == SLOW_DIV_LAST;
      rtc_second <= watch_tick && watch_cnt == WATCH_SECOND_LAST;
      if (hundred_khz_clock) begin
        third_cnt <= (third_cnt == THIRD_DIV_LAST) ? 2'h0 : third_cnt + 2'h1;
        slow_cnt <= (slow_cnt == SLOW_DIV_LAST) ? 7'h00 : slow_cnt + 7'h01;
      end
      if (watch_tick) begin
        watch_cnt <= watch_cnt + 15'h0001;
      end
    end
  end

  // ----------------------------------------
  // Central and fast tick counters
  // ----------------------------------------
  logic ctw_run;
  logic [CTW_W-1:0] tap_mask;

  assign ctw_run = !hibernate && !debug_halt;
  assign tap_mask = CTW_W'((32'h2 << ctw_tap) - 32'h1);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      central_tick_counter <= '0;
      ctw_irq <= 1'b0;
    end else begin
      ctw_irq <= 1'b0;
      if (ctw_clear) begin
        central_tick_counter <= '0;
      end else if (slow_tick_clock && ctw_run) begin
        central_tick_counter <= central_tick_counter + CTW_W'(1);
        ctw_irq <= (central_tick_counter & tap_mask) == tap_mask;
      end
    end
  end
  assign ctw_wake = ctw_irq;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ftw_count <= '0;
      ftw_irq <= 1'b0;
    end else begin
      ftw_irq <= 1'b0;
      if (hundred_khz_clock) begin
        if (ftw_count >= ftw_terminal) begin
          ftw_count <= '0;
          ftw_irq <= ftw_irq_en;
        end else begin
          ftw_count <= ftw_count + FTW_W'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // Source vector, master clock and divider trees
  // ----------------------------------------
  logic [7:0] src_vec;
  logic [NUM_SOURCES-1:0] base_src;

  // The master pick reads only the seven sources, so it cannot loop through itself.
  assign base_src = {watch_tick, hundred_khz_clock, pll_tick, rise[1],
                     doubler_tick, rise[0], main_osc_tick};
  assign master_tick = (master_sel == SRC_MASTER) ? 1'b0 : base_src[master_sel];
  assign src_vec = {master_tick, base_src};

  for (genvar i = 0; i < NUM_DIG_DIV; i++) begin : g_dig
    clk_divider #(.W(DIV_W)) u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .src_tick(src_vec),
      .sel(dig_sel[3*i +: 3]),
      .div(dig_div[DIV_W*i +: DIV_W]),
      .clk_out(dig_clk[i]),
      .tick_out(dig_tick[i])
    );
  end
  for (genvar i = 0; i < NUM_ANA_DIV; i++) begin : g_ana
    clk_divider #(.W(DIV_W)) u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .src_tick(src_vec),
      .sel(ana_sel[3*i +: 3]),
      .div(ana_div[DIV_W*i +: DIV_W]),
      .clk_out(ana_clk[i]),
      .tick_out(ana_tick[i])
    );
  end
  clk_divider #(.W(DIV_W)) u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .src_tick(src_vec),
    .sel(SRC_MASTER),
    .div(bus_div),
    .clk_out(bus_clk),
    .tick_out(bus_tick)
  );
  clk_divider #(.W(CPU_DIV_W)) u_cpu (
    .mclk(mclk),
    .rst_n(rst_n),
    .src_tick({8{bus_tick}}),
    .sel(SRC_MASTER),
    .div(cpu_div),
    .clk_out(cpu_clk),
    .tick_out(cpu_tick)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CTW_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (hibernate && !ctw_clear) |=> $stable(central_tick_counter))
    else $error("Central counter moved while stopped.");
  AST_CTW_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    ctw_clear |=> central_tick_counter == '0) else $error("Central counter not cleared.");
  AST_THIRD: assert property (@(posedge mclk) disable iff (!rst_n)
    third_rate_clock |-> $past(hundred_khz_clock) && $past(third_cnt) == THIRD_DIV_LAST)
    else $error("Third-rate clock not from 100 kHz.");
  AST_FTW_WRAP: assert property (@(posedge mclk) disable iff (!rst_n)
    (hundred_khz_clock && ftw_count >= ftw_terminal) |=> ftw_count == '0)
    else $error("Fast counter missed its terminal count.");
  AST_FTW_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    ftw_irq |-> $past(ftw_irq_en) && ftw_count == '0) else $error("Fast interrupt wrong.");
  AST_PLL_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(pll_locked) |-> $past(lock_cnt) == 32'(LOCK_CYCLES - 1) && pll_lock_event)
    else $error("PLL lock flag at wrong time.");
  AST_PLL_BYPASS: assert property (@(posedge mclk) disable iff (!rst_n)
    (pll_en && !pll_locked && ref_tick) |-> pll_tick) else $error("PLL source not passed.");
  AST_DBL: assert property (@(posedge mclk) disable iff (!rst_n)
    (doubler_ref == REF_MAIN && main_osc_tick) |-> doubler_tick)
    else $error("Doubler missed main oscillator edge.");
endmodule

// ### dv/osc_model.sv
// Purpose: Oscillators and pin clocks that feed the clock block.
// Assumes: Rates are scaled up so the slow counters finish quickly.
// Notes: Periods are unrelated to mclk, so edges land at any phase.
`timescale 1ns/100ps
module osc_model (
  // Source clocks
  output logic fast_crystal_osc,
  output logic interconnect_clk,
  output logic low_speed_osc,
  output logic watch_crystal_osc,
  output logic usb_frame
);
  // ----------------------------------------
  // Free-running sources
  // ----------------------------------------
  // Every level lasts over two mclk cycles, because the block synchronises these pins.
  initial begin
    fast_crystal_osc = 1'b0;
    interconnect_clk = 1'b0;
    low_speed_osc = 1'b0;
    watch_crystal_osc = 1'b0;
    usb_frame = 1'b0;
  end
  always #26.5 fast_crystal_osc = ~fast_crystal_osc;
  always #55.5 interconnect_clk = ~interconnect_clk;
  always #35.3 low_speed_osc = ~low_speed_osc;
  always #45.1 watch_crystal_osc = ~watch_crystal_osc;
  always begin
    #4970 usb_frame = 1'b1;
    #30 usb_frame = 1'b0;
  end
endmodule

// ### dv/clock_generation_distribution_bench.sv
// Purpose: Self-checking bench for the clock generation block.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: Rates are judged by counting source ticks between output ticks.
`timescale 1ns/100ps
module clock_generation_distribution_bench import clk_gen_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int LOCK = 20;
  localparam int CEIL = 30000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fast_crystal_osc, interconnect_clk, low_speed_osc, watch_crystal_osc, usb_frame;
  logic [2:0] main_range = 3'h3;
  logic [47:0] main_trim = 48'h0;
  logic usb_lock_en = 1'b1;
  logic [1:0] doubler_ref = REF_MAIN;
  logic [2:0] master_sel = SRC_FAST_XTAL;
  logic pll_en = 1'b0;
  logic [1:0] pll_ref = REF_MAIN;
  logic [5:0] pll_p = 6'h2;
  logic [5:0] pll_q = 6'h4;
  logic [23:0] dig_sel = 24'hFFFFFF;
  logic [127:0] dig_div = 128'h0;
  logic [11:0] ana_sel = 12'hFFF;
  logic [63:0] ana_div = 64'h0;
  logic [15:0] bus_div = 16'h4;
  logic [3:0] cpu_div = 4'h3;
  logic hibernate = 1'b0;
  logic debug_halt = 1'b0;
  logic ctw_clear = 1'b0;
  logic [3:0] ctw_tap = 4'h0;
  logic [4:0] ftw_terminal = 5'h2;
  logic ftw_irq_en = 1'b1;
  logic main_osc_tick, doubler_tick, pll_tick, master_tick, hundred_khz_clock;
  logic third_rate_clock, slow_tick_clock, watch_tick, bus_clk, bus_tick, cpu_clk, cpu_tick;
  logic pll_locked, pll_lock_event, ctw_irq, ctw_wake, ftw_irq, rtc_second;
  logic [7:0] dig_clk, dig_tick;
  logic [3:0] ana_clk, ana_tick;
  logic [12:0] central_tick_counter;
  logic [4:0] ftw_count;
  logic [3:0] srcv;
  logic [19:0] dstv;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  assign srcv = {ctw_irq && ctw_wake, hundred_khz_clock, bus_tick, master_tick};
  assign dstv = {pll_tick, doubler_tick, master_tick, slow_tick_clock, ftw_irq,
                 third_rate_clock, cpu_tick, bus_tick, ana_tick, dig_tick};
  always #5 mclk = ~mclk;
  osc_model i_osc_model (.fast_crystal_osc, .interconnect_clk, .low_speed_osc,
                         .watch_crystal_osc, .usb_frame);
  clock_generation_distribution #(.LOCK_CYCLES(LOCK)) i_clock_generation_distribution (
    .mclk, .rst_n, .fast_crystal_osc, .interconnect_clk, .low_speed_osc, .watch_crystal_osc,
    .usb_frame, .main_range, .main_trim, .usb_lock_en, .doubler_ref, .master_sel, .pll_en,
    .pll_ref, .pll_p, .pll_q, .dig_sel, .dig_div, .ana_sel, .ana_div, .bus_div, .cpu_div,
    .hibernate, .debug_halt, .ctw_clear, .ctw_tap, .ftw_terminal, .ftw_irq_en,
    .main_osc_tick, .doubler_tick, .pll_tick, .master_tick, .hundred_khz_clock,
    .third_rate_clock, .slow_tick_clock, .watch_tick, .dig_clk, .dig_tick, .ana_clk,
    .ana_tick, .bus_clk, .bus_tick, .cpu_clk, .cpu_tick, .pll_locked, .pll_lock_event,
    .central_tick_counter, .ctw_irq, .ctw_wake, .ftw_count, .ftw_irq, .rtc_second);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      fails++;
      test_done();
    end
  end
  // Counts source ticks after one output tick up to and including the next one.
  task automatic span(input int s, input int d, output int n);
    int k;
    n = 0;
    k = 0;
    while (dstv[d] !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    while (dstv[d] !== 1'b1 && k < 3000) begin
      n += int'(srcv[s] === 1'b1);
      @(negedge mclk);
      k++;
    end
    n += int'(srcv[s] === 1'b1);
  endtask
  // The first interval may still use the old setting, so only the second is judged.
  task automatic period(input string name, input int s, input int d, input int exp);
    int n;
    span(s, d, n);
    span(s, d, n);
    chk(name, n, exp);
  endtask
  task automatic window(input int d, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge mclk);
      n += int'(dstv[d] === 1'b1);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_div();
    for (int i = 0; i < NUM_DIG_DIV; i++) dig_div[16*i +: 16] = 16'(i + 2);
    for (int i = 1; i < NUM_ANA_DIV; i++) ana_div[16*i +: 16] = 16'(i + 5);
    for (int i = 0; i < NUM_DIG_DIV; i++) period("dig", 0, i, i + 2);
    for (int i = 0; i < NUM_ANA_DIV; i++) period("ana", 0, 8 + i, i ? i + 5 : 2);
    period("bus", 0, 12, 4);
    period("cpu", 1, 13, 3);
    cpu_div = 4'hF;
    period("cpu_max", 1, 13, 15);
    dig_sel[2:0] = SRC_LOW_SPEED;
    period("dig_src", 2, 0, 2);
  endtask
  task automatic t_pll();
    int n;
    for (int r = 0; r < 3; r++) begin
      pll_ref = 2'(r);
      pll_en = 1'b1;
      n = 0;
      while (pll_locked !== 1'b1 && n < 100) begin
        @(negedge mclk);
        n++;
      end
      chk("lock_time", n >= LOCK && n <= LOCK + 1, 1);
      chk("lock_event", pll_lock_event, 1);
      @(negedge mclk);
      chk("event_once", pll_lock_event, 0);
      pll_en = 1'b0;
      repeat (2) @(negedge mclk);
      chk("unlock", pll_locked, 0);
    end
  endtask
  task automatic t_rate();
    int f, d, p;
    doubler_ref = REF_FAST_XTAL;
    pll_ref = REF_FAST_XTAL;
    pll_en = 1'b1;
    repeat (60) @(negedge mclk);
    window(17, 530, f);
    window(18, 530, d);
    window(19, 530, p);
    chk("doubler", d >= 2 * f - 2 && d <= 2 * f + 2, 1);
    chk("pll_rate", p >= 2 * f - 2 && p <= 2 * f + 2, 1);
    for (int m = 0; m < 8; m++) begin
      master_sel = 3'(m);
      window(17, 200, f);
      chk("master_src", f > 0, m < NUM_SOURCES);
    end
    master_sel = SRC_FAST_XTAL;
  endtask
  task automatic t_low();
    int n;
    period("third", 2, 14, 3);
    period("slow", 2, 16, 100);
    period("ftw", 2, 15, 3);
    ftw_terminal = 5'h1F;
    period("ftw_max", 2, 15, 32);
    ftw_irq_en = 1'b0;
    window(15, 300, n);
    chk("ftw_quiet", n, 0);
  endtask
  task automatic t_ctw();
    logic [12:0] v;
    int n;
    for (int c = 0; c < 3; c++) begin
      hibernate = (c == 1);
      debug_halt = (c == 2);
      span(2, 16, n);
      repeat (3) @(negedge mclk);
      v = central_tick_counter;
      span(3, 16, n);
      chk("ctw_irq", n, c == 0 && v[0]);
      repeat (3) @(negedge mclk);
      chk("ctw", central_tick_counter, c ? v : v + 13'h2);
    end
    ctw_clear = 1'b1;
    repeat (2) @(negedge mclk);
    ctw_clear = 1'b0;
    chk("ctw_clear", central_tick_counter, 0);
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    chk("reset_lock", pll_locked, 0);
    chk("reset_ctw", central_tick_counter, 0);
    rst_n = 1'b1;
    @(negedge mclk);
    t_div();
    t_pll();
    t_rate();
    t_low();
    t_ctw();
    test_done();
  end
endmodule
